// ===== ulc_defs.vh
`ifndef ULC_DEFS_VH
`define ULC_DEFS_VH
// ----------------------------------------
// Register indices (byte address = index)
// ----------------------------------------
`define ULC_A_DATA 3'h0
`define ULC_A_DIVM 3'h1
`define ULC_A_FIFO 3'h2
`define ULC_A_LINE 3'h3
`define ULC_A_MODEM 3'h4
`define ULC_A_FEAT 3'h5
`define ULC_A_TRIG 3'h6
`define ULC_A_ENH 3'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ULC_FC_EN 0
`define ULC_LC_DIV 7
`define ULC_LC_BRK 6
`define ULC_LC_FORCE 5
`define ULC_LC_EVEN 4
`define ULC_LC_PAR 3
`define ULC_LC_STOP 2
`define ULC_MC_PRE 7
`define ULC_MC_IR 6
`define ULC_MC_XANY 5
`define ULC_MC_LOOP 4
`define ULC_MC_SCI 3
`define ULC_FT_RXINV 4
`define ULC_EF_ENH 4
`define ULC_EF_SWFC 3
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define ULC_RST_BYTE 8'h00
`define ULC_RST_TRIG 8'h01
`define ULC_PRE_DIV 2'h3
`endif

// ===== ulc_channel.v
`timescale 1ns/1ps
`include "ulc_defs.vh"
// Function
// - FIFO enable bit must be set in same write for other fields to load.
// - Table 00: rx levels 1,4,8,14; tx level fixed 1.
// - Table 01: rx 8,16,24,28; tx 16,8,24,30.
// - Table 10: rx 8,16,56,60; tx 8,16,32,56.
// - Table 11: levels come from programmable rx and tx trigger registers.
// - Divisor-access bit maps data locations to divisor latches.
// - Break bit forces transmit output low until cleared.
// - Parity enable adds parity bit on transmit and checks on receive.
// - Even-select 0 gives odd count of ones, 1 gives even.
// - Forced parity is 1 when even-select 0, 0 when even-select 1.
// - Stop bit 0 gives one stop; 1 gives 1.5 for 5-bit, else 2.
// - Word length field 00..11 selects 5..8 data bits.
// - Prescaler, infrared and Xon-any bits writable only with enhanced enable.
// - Prescaler 1 divides baud source by four, else undivided.
// - Infrared enable loads strap level at reset release.
// - Infrared mode routes serial through codec, tx idles low, rx may invert.
// - Exact infrared pulse width only at 16x and zero fraction field.
// - With Xon-any, any received character resumes suspended transmission.
// - Loopback bit selects local loopback mode.
// - Send-immediate byte goes ahead of FIFO bytes; bit self-clears when the byte is written.
// - With the ULC_EF_SWFC bit set, pending Xon/Xoff characters go before the send-immediate byte.
// - In loopback, carrier-detect status mirrors the send-immediate bit.
module ulc_channel (
    input wire core_clk,
    input wire resetn,
    input wire [2:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    input wire infraredStrapPin,
    input wire txBusy,
    input wire shiftLoad,
    input wire xonXoffPending,
    input wire flowSuspended,
    input wire rxCharDone,
    input wire [7:0] txChar,
    input wire serialTxRaw,
    input wire irTxPulse,
    input wire serialRxPin,
    input wire fracZero,
    input wire sample16x,
    output reg serialTxPin,
    output wire rxToCore,
    output wire rxToDecoder,
    output reg [6:0] rxTrigLevel,
    output reg [6:0] txTrigLevel,
    output reg fifoEnable,
    output wire divisorAccess,
    output wire [3:0] wordBits,
    output wire parityEnable,
    output wire [1:0] stopHalfBits,
    output wire txParityBit,
    output wire rxParityOk,
    input wire [7:0] rxChar,
    input wire rxParityIn,
    output reg baudTick,
    output wire infraredMode,
    output wire irPulseExact,
    output wire loopbackMode,
    output wire carrierDetect,
    output reg flowResume,
    output reg sendImmValid,
    output reg [7:0] sendImmByte,
    input wire sendImmTaken
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Each instance holds its own copy, so two channels never interact
    reg [7:0] fifoCtl_ff;
    reg [7:0] lineCtl_ff;
    reg [7:0] modemCtl_ff;
    reg [7:0] featCtl_ff;
    reg [7:0] enhCtl_ff;
    reg [7:0] rxTrigReg_ff;
    reg [7:0] txTrigReg_ff;
    reg [7:0] divHigh_ff;
    reg [7:0] divLow_ff;
    reg [7:0] divFrac_ff;
    reg strapPend_ff;
    reg [1:0] preCnt_ff;
    reg sciArmed_ff;
    reg [7:0] nxt_modemCtl;

    wire enhOn = enhCtl_ff[`ULC_EF_ENH];
    wire isWr = regWr;
    // Extra divisor-fraction byte sits in the feature slot while latched
    wire dataWr = isWr && regAddr == `ULC_A_DATA && !lineCtl_ff[`ULC_LC_DIV];

    assign divisorAccess = lineCtl_ff[`ULC_LC_DIV];

    // ----------------------------------------
    // Send-immediate handoff
    // ----------------------------------------
    // Byte leaves only when the shift register is free and loading
    // With ULC_EF_SWFC set, flow characters win the shift register over the immediate byte
    wire immMayLoad = sendImmValid && shiftLoad &&
        !(enhCtl_ff[`ULC_EF_SWFC] && xonXoffPending) && !txBusy;

    // ----------------------------------------
    // Trigger table decode
    // ----------------------------------------
    function [6:0] rxLevel;
        input [1:0] tab;
        input [1:0] code;
        input [7:0] prog;
        begin
            case (tab)
                2'h0: begin
                    case (code)
                        2'h0: rxLevel = 7'h01;
                        2'h1: rxLevel = 7'h04;
                        2'h2: rxLevel = 7'h08;
                        default: rxLevel = 7'h0e;
                    endcase
                end
                2'h1: begin
                    case (code)
                        2'h0: rxLevel = 7'h08;
                        2'h1: rxLevel = 7'h10;
                        2'h2: rxLevel = 7'h18;
                        default: rxLevel = 7'h1c;
                    endcase
                end
                2'h2: begin
                    case (code)
                        2'h0: rxLevel = 7'h08;
                        2'h1: rxLevel = 7'h10;
                        2'h2: rxLevel = 7'h38;
                        default: rxLevel = 7'h3c;
                    endcase
                end
                default: rxLevel = prog[6:0];
            endcase
        end
    endfunction

    function [6:0] txLevel;
        input [1:0] tab;
        input [1:0] code;
        input [7:0] prog;
        begin
            case (tab)
                2'h0: txLevel = 7'h01;
                2'h1: begin
                    case (code)
                        2'h0: txLevel = 7'h10;
                        2'h1: txLevel = 7'h08;
                        2'h2: txLevel = 7'h18;
                        default: txLevel = 7'h1e;
                    endcase
                end
                2'h2: begin
                    case (code)
                        2'h0: txLevel = 7'h08;
                        2'h1: txLevel = 7'h10;
                        2'h2: txLevel = 7'h20;
                        default: txLevel = 7'h38;
                    endcase
                end
                default: txLevel = prog[6:0];
            endcase
        end
    endfunction

    always @* begin
        rxTrigLevel = rxLevel(featCtl_ff[7:6], fifoCtl_ff[7:6], rxTrigReg_ff);
        txTrigLevel = txLevel(featCtl_ff[7:6], fifoCtl_ff[5:4], txTrigReg_ff);
        fifoEnable = fifoCtl_ff[`ULC_FC_EN];
    end

    // ----------------------------------------
    // Modem control next value
    // ----------------------------------------
    always @* begin
        nxt_modemCtl = modemCtl_ff;
        if (isWr && regAddr == `ULC_A_MODEM) begin
            nxt_modemCtl[4:0] = regWdata[4:0];
            if (enhOn) begin
                nxt_modemCtl[7:5] = regWdata[7:5];
            end
        end
        // Self-clear once the immediate byte is captured
        if (dataWr && sciArmed_ff) begin
            nxt_modemCtl[`ULC_MC_SCI] = 1'b0;
        end
        if (strapPend_ff) begin
            nxt_modemCtl[`ULC_MC_IR] = infraredStrapPin;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fifoCtl_ff <= `ULC_RST_BYTE;
            lineCtl_ff <= `ULC_RST_BYTE;
            modemCtl_ff <= `ULC_RST_BYTE;
            featCtl_ff <= `ULC_RST_BYTE;
            enhCtl_ff <= `ULC_RST_BYTE;
            rxTrigReg_ff <= `ULC_RST_TRIG;
            txTrigReg_ff <= `ULC_RST_TRIG;
            divHigh_ff <= `ULC_RST_BYTE;
            divLow_ff <= `ULC_RST_BYTE;
            divFrac_ff <= `ULC_RST_BYTE;
            strapPend_ff <= 1'b1;
            sciArmed_ff <= 1'b0;
            sendImmValid <= 1'b0;
            sendImmByte <= `ULC_RST_BYTE;
        end else begin
            // Strap caught on the first clock after release, not at reset
            strapPend_ff <= 1'b0;
            modemCtl_ff <= nxt_modemCtl;
            if (isWr) begin
                case (regAddr)
                    `ULC_A_DATA: begin
                        if (lineCtl_ff[`ULC_LC_DIV]) begin
                            divLow_ff <= regWdata;
                        end
                    end
                    `ULC_A_DIVM: begin
                        if (lineCtl_ff[`ULC_LC_DIV]) begin
                            divHigh_ff <= regWdata;
                        end
                    end
                    `ULC_A_FIFO: begin
                        if (regWdata[`ULC_FC_EN]) begin
                            fifoCtl_ff <= regWdata;
                        end else begin
                            fifoCtl_ff[`ULC_FC_EN] <= 1'b0;
                        end
                    end
                    `ULC_A_LINE: lineCtl_ff <= regWdata;
                    `ULC_A_FEAT: begin
                        if (lineCtl_ff[`ULC_LC_DIV]) begin
                            divFrac_ff <= regWdata;
                        end else begin
                            featCtl_ff <= regWdata;
                        end
                    end
                    `ULC_A_TRIG: begin
                        if (featCtl_ff[7:6] == 2'h3) begin
                            rxTrigReg_ff <= regWdata;
                            txTrigReg_ff <= regWdata;
                        end
                    end
                    `ULC_A_ENH: enhCtl_ff <= regWdata;
                    default: begin
                    end
                endcase
            end
            // Only the access straight after setting the bit counts
            if (isWr || regRd) begin
                sciArmed_ff <= isWr && regAddr == `ULC_A_MODEM && regWdata[`ULC_MC_SCI];
            end
            if (dataWr && sciArmed_ff) begin
                sendImmValid <= 1'b1;
                sendImmByte <= regWdata;
            end else if (sendImmTaken && immMayLoad) begin
                // Core taking it while flow bytes wait would reorder the line
                sendImmValid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= `ULC_RST_BYTE;
        end else if (regRd) begin
            case (regAddr)
                `ULC_A_DATA: regRdata <= divisorAccess ? divLow_ff : `ULC_RST_BYTE;
                `ULC_A_DIVM: regRdata <= divisorAccess ? divHigh_ff : `ULC_RST_BYTE;
                `ULC_A_FIFO: regRdata <= {fifoEnable, fifoEnable, 6'h00};
                `ULC_A_LINE: regRdata <= lineCtl_ff;
                `ULC_A_MODEM: regRdata <= modemCtl_ff;
                `ULC_A_FEAT: regRdata <= divisorAccess ? divFrac_ff : featCtl_ff;
                `ULC_A_TRIG: regRdata <= {1'b0, rxTrigLevel};
                default: regRdata <= enhCtl_ff;
            endcase
        end else begin
            regRdata <= `ULC_RST_BYTE;
        end
    end

    // ----------------------------------------
    // Character format
    // ----------------------------------------
    assign wordBits = {2'h0, lineCtl_ff[1:0]} + 4'h5;
    assign parityEnable = lineCtl_ff[`ULC_LC_PAR];
    // Counted in half bits: 2, 3, or 0 standing for 4 (two-bit field wraps)
    assign stopHalfBits = !lineCtl_ff[`ULC_LC_STOP] ? 2'h2 :
        (lineCtl_ff[1:0] == 2'h0) ? 2'h3 : 2'h0;

    function parOf;
        input [7:0] d;
        input [1:0] wl;
        input even;
        input force_;
        reg x;
        begin
            x = ^(d & (8'h1f | (8'he0 >> (2'h3 - wl))));
            if (force_) begin
                parOf = ~even;
            end else begin
                parOf = even ? x : ~x;
            end
        end
    endfunction

    assign txParityBit = parOf(txChar, lineCtl_ff[1:0], lineCtl_ff[`ULC_LC_EVEN],
        lineCtl_ff[`ULC_LC_FORCE]);
    assign rxParityOk = !parityEnable || (rxParityIn == parOf(rxChar, lineCtl_ff[1:0],
        lineCtl_ff[`ULC_LC_EVEN], lineCtl_ff[`ULC_LC_FORCE]));

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            preCnt_ff <= 2'h0;
            baudTick <= 1'b0;
        end else begin
            preCnt_ff <= preCnt_ff + 2'h1;
            baudTick <= !modemCtl_ff[`ULC_MC_PRE] || preCnt_ff == `ULC_PRE_DIV;
        end
    end

    // ----------------------------------------
    // Serial path, infrared, loopback
    // ----------------------------------------
    assign infraredMode = modemCtl_ff[`ULC_MC_IR];
    assign loopbackMode = modemCtl_ff[`ULC_MC_LOOP];
    assign rxToDecoder = serialRxPin ^ featCtl_ff[`ULC_FT_RXINV];
    // Loopback feeds the core's own transmit stream back, line held idle unless break is set
    assign rxToCore = loopbackMode ? serialTxRaw : serialRxPin;
    assign irPulseExact = infraredMode && sample16x && fracZero;
    assign carrierDetect = loopbackMode && modemCtl_ff[`ULC_MC_SCI];

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            serialTxPin <= 1'b1;
            flowResume <= 1'b0;
        end else begin
            if (lineCtl_ff[`ULC_LC_BRK]) begin
                serialTxPin <= 1'b0;
            end else if (loopbackMode) begin
                serialTxPin <= !infraredMode;
            end else if (infraredMode) begin
                serialTxPin <= irTxPulse;
            end else begin
                serialTxPin <= serialTxRaw;
            end
            flowResume <= modemCtl_ff[`ULC_MC_XANY] && flowSuspended && rxCharDone;
        end
    end
endmodule

// ===== ulc_channel_assertions.sv
`timescale 1ns/1ps
`include "ulc_defs.vh"
module ulc_channel_assertions (
    input wire core_clk,
    input wire resetn,
    input wire [2:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdata,
    input wire [7:0] txChar,
    input wire serialTxPin,
    input wire divisorAccess,
    input wire [3:0] wordBits,
    input wire parityEnable,
    input wire [1:0] stopHalfBits,
    input wire txParityBit,
    input wire loopbackMode,
    input wire carrierDetect,
    input wire sendImmValid,
    input wire [7:0] sendImmByte
);
default clocking @(posedge core_clk); endclocking
default disable iff (!resetn);
// ----------------
// Shadow registers
// ----------------
reg [7:0] lineSh_ff;
reg loopSh_ff;
wire [7:0] txMask = 8'hff >> (2'h3 - lineSh_ff[1:0]);
wire dataPar = ^(txChar & txMask);
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        lineSh_ff <= 8'h00;
        loopSh_ff <= 1'b0;
    end else if (regWr && regAddr == `ULC_A_LINE) begin
        lineSh_ff <= regWdata;
    end else if (regWr && regAddr == `ULC_A_MODEM) begin
        loopSh_ff <= regWdata[`ULC_MC_LOOP];
    end
end
// ----------------
// Properties
// ----------------
sequence sciSet;
    regWr && regAddr == `ULC_A_MODEM && regWdata[3] && !regWdata[4];
endsequence
sequence busIdle;
    !regWr && !regRd;
endsequence
sequence immWr;
    regWr && regAddr == `ULC_A_DATA && !divisorAccess;
endsequence
div_access_a: assert property (divisorAccess == lineSh_ff[7])
    else $error("divisor access wrong");
par_enable_a: assert property (parityEnable == lineSh_ff[3])
    else $error("parity enable wrong");
word_len_a: assert property (wordBits == 4'h5 + {2'h0, lineSh_ff[1:0]})
    else $error("word length wrong");
stop_len_a: assert property (stopHalfBits == (!lineSh_ff[2] ? 2'h2 :
    (lineSh_ff[1:0] == 2'h0 ? 2'h3 : 2'h0))) else $error("stop length wrong");
par_calc_a: assert property (lineSh_ff[3] && !lineSh_ff[5] |->
    txParityBit == (dataPar ^ !lineSh_ff[4])) else $error("parity value wrong");
par_force_a: assert property (lineSh_ff[3] && lineSh_ff[5] |->
    txParityBit == !lineSh_ff[4]) else $error("forced parity wrong");
brk_low_a: assert property (lineSh_ff[6] && $past(lineSh_ff[6]) |-> !serialTxPin)
    else $error("break not low");
loop_mode_a: assert property (loopbackMode == loopSh_ff)
    else $error("loopback mode wrong");
loop_cd_a: assert property (regWr && regAddr == `ULC_A_MODEM && regWdata[4] |=>
    carrierDetect == $past(regWdata[3])) else $error("carrier mirror wrong");
send_imm_a: assert property (sciSet ##1 busIdle ##1 immWr |=>
    sendImmValid && sendImmByte == $past(regWdata)) else $error("immediate byte lost");
rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not idle");
endmodule

// ===== ulc_remote_model.sv
`timescale 1ns/1ps
module ulc_remote_model (
    input wire core_clk,
    input wire txLine,
    input wire [7:0] sendByte,
    input wire sendGo,
    output reg rxLine,
    output reg breakSeen
);
// ----------------
// Line driver
// ----------------
reg [9:0] frame = 10'h3ff;
reg [3:0] lowRun = 4'h0;
initial rxLine = 1'b1;
initial breakSeen = 1'b0;
always @(posedge core_clk) begin
    // Idle line rests at mark, as a pulled-up line would
    if (sendGo)
        frame <= {1'b1, sendByte, 1'b0};
    else
        frame <= {1'b1, frame[9:1]};
    rxLine <= sendGo ? 1'b1 : frame[0];
    // Space of a whole frame (10 cycles) or longer counts as break
    lowRun <= txLine ? 4'h0 : lowRun + {3'h0, lowRun != 4'hf};
    breakSeen <= lowRun >= 4'ha;
end
endmodule

// ===== ulc_channel_tb.sv
`timescale 1ns/1ps
`include "ulc_defs.vh"
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module ulc_channel_tb;
reg core_clk, resetn, regWr, regRd, infraredStrapPin, txBusy, shiftLoad, xonXoffPending;
reg flowSuspended, rxCharDone, serialTxRaw, irTxPulse, fracZero, sample16x, rxParityIn;
reg sendImmTaken, sendGo;
reg [2:0] regAddr;
reg [7:0] regWdata, txChar, rxChar, rdv, d;
wire [7:0] regRdata, sendImmByte;
wire [6:0] rxTrigLevel, txTrigLevel;
wire [3:0] wordBits;
wire [1:0] stopHalfBits;
wire serialTxPin, rxToCore, rxToDecoder, fifoEnable, divisorAccess, parityEnable, txParityBit;
wire rxParityOk, baudTick, infraredMode, irPulseExact, loopbackMode, carrierDetect;
wire flowResume, sendImmValid, serialRxPin, breakSeen;
int error_cnt = 0, compares = 0, cyc = 0, n, i, k;
reg e;
reg [31:0] rows [0:13];
ulc_channel dut (.core_clk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .infraredStrapPin, .txBusy, .shiftLoad, .xonXoffPending, .flowSuspended, .rxCharDone,
    .txChar, .serialTxRaw, .irTxPulse, .serialRxPin, .fracZero, .sample16x, .serialTxPin,
    .rxToCore, .rxToDecoder, .rxTrigLevel, .txTrigLevel, .fifoEnable, .divisorAccess,
    .wordBits, .parityEnable, .stopHalfBits, .txParityBit, .rxParityOk, .rxChar, .rxParityIn,
    .baudTick, .infraredMode, .irPulseExact, .loopbackMode, .carrierDetect, .flowResume,
    .sendImmValid, .sendImmByte, .sendImmTaken);
ulc_remote_model peer (.core_clk, .txLine(serialTxPin), .sendByte(8'h5a), .sendGo,
    .rxLine(serialRxPin), .breakSeen);
// ----------------
// Bus tasks
// ----------------
task wr(input [2:0] a, input [7:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
endtask
task rd(input [2:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
endtask
task take;
    @(posedge core_clk);
    {sendImmTaken, shiftLoad} <= 2'h3;
    @(posedge core_clk);
    {sendImmTaken, shiftLoad} <= 2'h0;
    #1;
endtask
task tick(input int t);
    repeat (t) @(posedge core_clk);
    #1;
endtask
task cnt8(output int c);
    c = 0;
    repeat (8) begin
        @(posedge core_clk);
        #1;
        if (baudTick === 1'b1) c++;
    end
endtask
task give_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
// ----------------
// Clock and guard
// ----------------
initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
end
// Whole run is a few hundred cycles
always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
        error_cnt++;
        give_verdict;
    end
end
// ----------------
// Sequence
// ----------------
initial begin
    {resetn, regWr, regRd, txBusy, shiftLoad, xonXoffPending, flowSuspended} = 7'h00;
    {rxCharDone, irTxPulse, rxParityIn, sendImmTaken, sendGo} = 5'h00;
    {infraredStrapPin, serialTxRaw, fracZero, sample16x} = 4'hf;
    {regAddr, regWdata, txChar, rxChar} = 27'h0;
    rows = '{32'h00010101, 32'h00710401, 32'h00810801, 32'h00f10e01, 32'h40010810,
        32'h40511008, 32'h40a11818, 32'h40f11c1e, 32'h80010808, 32'h80511010,
        32'h80a13820, 32'h80f13c38, 32'hc0012020, 32'hc0f13c3c};
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    tick(1);
    `CK("fifo en", 1'b0, fifoEnable)
    `CK("rx trig", 7'h01, rxTrigLevel)
    `CK("strap", 1'b1, infraredMode)
    wr(`ULC_A_MODEM, 8'he0);
    rd(`ULC_A_MODEM);
    `CK("modem lock", 8'h40, rdv)
    `CK("ir idle", 1'b0, serialTxPin)
    `CK("ir exact", 1'b1, irPulseExact)
    wr(`ULC_A_FEAT, 8'h10);
    `CK("rx invert", ~serialRxPin, rxToDecoder)
    @(posedge core_clk);
    fracZero <= 1'b0;
    tick(1);
    `CK("ir frac", 1'b0, irPulseExact)
    @(posedge core_clk);
    fracZero <= 1'b1;
    sample16x <= 1'b0;
    tick(1);
    `CK("ir 16x", 1'b0, irPulseExact)
    $display("infrared test done");
    wr(`ULC_A_ENH, 8'h10);
    wr(`ULC_A_MODEM, 8'h80);
    cnt8(n);
    `CK("quarter", 2, n)
    `CK("ir off", 1'b0, infraredMode)
    wr(`ULC_A_MODEM, 8'h00);
    cnt8(n);
    `CK("full", 8, n)
    $display("baud test done");
    for (i = 0; i < 14; i++) begin
        wr(`ULC_A_FEAT, rows[i][31:24]);
        if (rows[i][31:30] == 2'h3) wr(`ULC_A_TRIG, rows[i][15:8]);
        wr(`ULC_A_FIFO, rows[i][23:16]);
        `CK("rx level", rows[i][14:8], rxTrigLevel)
        `CK("tx level", rows[i][6:0], txTrigLevel)
    end
    wr(`ULC_A_FEAT, 8'h00);
    wr(`ULC_A_FIFO, 8'hc1);
    rd(`ULC_A_FIFO);
    `CK("fifo rd", 8'hc0, rdv)
    // Fields without the enable bit must not land
    wr(`ULC_A_FIFO, 8'h40);
    `CK("fifo off", 1'b0, fifoEnable)
    `CK("rx kept", 7'h0e, rxTrigLevel)
    $display("trigger test done");
    for (i = 0; i < 4; i++) begin
        wr(`ULC_A_LINE, 8'h04 | i[7:0]);
        `CK("word", 4'h5 + i[3:0], wordBits)
        `CK("stop", (i == 0) ? 2'h3 : 2'h0, stopHalfBits)
    end
    wr(`ULC_A_LINE, 8'h03);
    `CK("stop one", 2'h2, stopHalfBits)
    `CK("par off", 1'b0, parityEnable)
    for (k = 0; k < 2; k++) begin
        d = k ? 8'h03 : 8'h07;
        @(posedge core_clk);
        txChar <= d;
        rxChar <= d;
        rxParityIn <= k[0];
        for (i = 0; i < 4; i++) begin
            wr(`ULC_A_LINE, 8'h0b | (i[7:0] << 4));
            e = (i > 1) ? (i == 2) : (^d ^ (i == 0));
            `CK("par on", 1'b1, parityEnable)
            `CK("tx par", e, txParityBit)
            `CK("rx par", e == k[0], rxParityOk)
        end
    end
    `CK("div off", 1'b0, divisorAccess)
    wr(`ULC_A_LINE, 8'h80);
    `CK("div on", 1'b1, divisorAccess)
    $display("format test done");
    wr(`ULC_A_LINE, 8'h40);
    tick(13);
    `CK("break", 1'b0, serialTxPin)
    `CK("break seen", 1'b1, breakSeen)
    wr(`ULC_A_LINE, 8'h00);
    tick(2);
    `CK("mark", 1'b1, serialTxPin)
    $display("break test done");
    for (i = 0; i < 2; i++) begin
        wr(`ULC_A_MODEM, i ? 8'h20 : 8'h00);
        @(posedge core_clk);
        flowSuspended <= 1'b1;
        rxCharDone <= 1'b1;
        @(posedge core_clk);
        rxCharDone <= 1'b0;
        n = 0;
        repeat (4) begin
            #1;
            if (flowResume === 1'b1) n++;
            @(posedge core_clk);
        end
        `CK("resume", i, n)
    end
    wr(`ULC_A_MODEM, 8'h18);
    `CK("loop", 1'b1, loopbackMode)
    `CK("cd on", 1'b1, carrierDetect)
    wr(`ULC_A_MODEM, 8'h10);
    `CK("cd off", 1'b0, carrierDetect)
    wr(`ULC_A_MODEM, 8'h00);
    `CK("loop off", 1'b0, loopbackMode)
    $display("modem test done");
    wr(`ULC_A_MODEM, 8'h08);
    wr(`ULC_A_DATA, 8'haa);
    `CK("imm valid", 1'b1, sendImmValid)
    `CK("imm byte", 8'haa, sendImmByte)
    rd(`ULC_A_MODEM);
    `CK("imm clear", 8'h00, rdv)
    take;
    `CK("imm taken", 1'b0, sendImmValid)
    wr(`ULC_A_ENH, 8'h18);
    @(posedge core_clk);
    xonXoffPending <= 1'b1;
    wr(`ULC_A_MODEM, 8'h08);
    wr(`ULC_A_DATA, 8'hbb);
    take;
    `CK("flow first", 1'b1, sendImmValid)
    @(posedge core_clk);
    xonXoffPending <= 1'b0;
    take;
    `CK("imm after flow", 1'b0, sendImmValid)
    @(posedge core_clk);
    sendGo <= 1'b1;
    @(posedge core_clk);
    sendGo <= 1'b0;
    repeat (10) begin
        tick(1);
        `CK("rx path", serialRxPin, rxToCore)
    end
    $display("immediate test done");
    give_verdict;
end
endmodule
bind ulc_channel ulc_channel_assertions chk (.core_clk, .resetn, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .txChar, .serialTxPin, .divisorAccess, .wordBits,
    .parityEnable, .stopHalfBits, .txParityBit, .loopbackMode, .carrierDetect,
    .sendImmValid, .sendImmByte);
